// ===== logic/tmr_counter_capture.sv
// 16-bit timer counter with input capture and a shared high-byte holding register.
`timescale 1ns/100ps
`default_nettype none
`include "tmr_regs.svh"

// Operation
// - Clock select zero stops the counter
// - Counter counts up, down or clears
// - Low-byte access moves upper byte via holding
// - Upper-byte location always means holding register
// - Counter accessible with clock stopped
// - Processor write beats count or clear
// - Waveform mode field sets counting sequence
// - Overflow flag set where mode defines
// - Edge copies counter to capture, sets flag
// - Capture flag interrupts; cleared by ack/one
// - Capture low read loads holding register
// - Capture writable only in capture-top modes
// - Select bit routes comparator to capture
// - Source switch may capture; software clears flag
// - Capture input synchronised; filter adds delay
// - Capture input off in capture-top modes
// - Filter changes after four agreeing samples
// - Filter enabled by bit, system clocked
// - New capture overwrites unread capture value
// - Driving pin from software causes capture
// - One holding register for all upper bytes
module tmr_counter_capture #(
	parameter int NC_SAMPLES = `TMR_NC_SAMPLES
) (
	input  wire logic              CORE_CLK,
	input  wire logic              RSTN,
	input  wire logic              CE,
	input  wire tmr_pkg::tmr_bus_s  BUS,
	input  wire tmr_pkg::tmr_ctrl_s CTRL,
	input  wire logic              PRESCALE_TICK,
	input  wire logic              EXTERNAL_COUNT_PIN,
	input  wire logic              CAPTURE_INPUT_PIN,
	input  wire logic              COMPARATOR_OUTPUT,
	output logic [7:0]             BUS_RDATA,
	output logic [15:0]            COUNT_VALUE,
	output logic [15:0]            CAPTURE_VALUE,
	output logic                   OVERFLOW_FLAG,
	output logic                   CAPTURE_FLAG,
	output logic                   OVERFLOW_IRQ,
	output logic                   CAPTURE_IRQ
);
	import tmr_pkg::*;

	if (NC_SAMPLES < 2 || NC_SAMPLES > `TMR_NC_SAMPLES) begin : g_chk
		$error("NC_SAMPLES out of range");
	end

	tmr_state_s q_ff;
	tmr_state_s nxt_q;

	// Modes whose top comes from the capture register.
	function automatic logic capt_top(input logic [3:0] m);
		return (m == 4'h8) || (m == 4'hA) || (m == 4'hC) || (m == 4'hE);
	endfunction

	function automatic logic dual_slope(input logic [3:0] m);
		return (m inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB});
	endfunction

	function automatic logic single_wrap(input logic [3:0] m);
		return (m inside {4'h5, 4'h6, 4'h7, 4'hE, 4'hF});
	endfunction

	function automatic logic [15:0] top_of(input logic [3:0] m, input logic [15:0] icr,
		input logic [15:0] ocr);
		unique case (m)
			4'h1, 4'h5: return `TMR_TOP_8BIT;
			4'h2, 4'h6: return `TMR_TOP_9BIT;
			4'h3, 4'h7: return `TMR_TOP_10BIT;
			4'h4, 4'h9, 4'hB, 4'hF: return ocr;
			4'h8, 4'hA, 4'hC, 4'hE: return icr;
			default: return `TMR_MAX;
		endcase
	endfunction

	logic        tick;
	logic        cap_evt;
	logic        edge_src;
	logic [15:0] top;
	logic        wr_cnt_lo;
	logic        ext_rise;
	logic        ext_fall;

	assign wr_cnt_lo = BUS.wr && (BUS.addr == `TMR_LOC_COUNT_LO);
	assign ext_rise  = q_ff.ext_s2 && !q_ff.ext_prev;
	assign ext_fall  = !q_ff.ext_s2 && q_ff.ext_prev;
	assign top       = top_of(CTRL.waveform_mode_field, q_ff.capt, CTRL.compare_a_top);
	assign edge_src  = CTRL.noise_filter_enable ? q_ff.filt : q_ff.src_s2;

	always_comb begin
		unique case (CTRL.clock_source_select)
			`TMR_CS_NONE:     tick = 1'b0;
			`TMR_CS_DIRECT:   tick = 1'b1;
			`TMR_CS_EXT_FALL: tick = ext_fall;
			`TMR_CS_EXT_RISE: tick = ext_rise;
			default:          tick = PRESCALE_TICK;
		endcase
	end

	// Capture edges are ignored while the capture register holds the top value.
	always_comb begin
		cap_evt = 1'b0;
		if (!capt_top(CTRL.waveform_mode_field)) begin
			if (CTRL.edge_rising) begin
				cap_evt = edge_src && !q_ff.edge_prev;
			end else begin
				cap_evt = !edge_src && q_ff.edge_prev;
			end
		end
	end

	always_comb begin
		logic ovf_set;
		logic all_hi;
		logic all_lo;
		ovf_set = 1'b0;
		all_hi  = 1'b1;
		all_lo  = 1'b1;
		nxt_q   = q_ff;

		// Pin and comparator are muxed ahead of the synchroniser, so a source
		// switch can look like an edge and software must clear the flag.
		nxt_q.src_s1 = CTRL.comparator_capture_select ? COMPARATOR_OUTPUT
			: CAPTURE_INPUT_PIN;
		nxt_q.src_s2 = q_ff.src_s1;
		nxt_q.ext_s1 = EXTERNAL_COUNT_PIN;
		nxt_q.ext_s2 = q_ff.ext_s1;
		nxt_q.ext_prev = q_ff.ext_s2;

		// The window includes the sample shifted in now, so the filter adds four cycles.
		nxt_q.samp = {q_ff.samp[`TMR_NC_SAMPLES-2:0], q_ff.src_s2};
		for (int i = 0; i < NC_SAMPLES; i++) begin
			all_hi = all_hi & nxt_q.samp[i];
			all_lo = all_lo & !nxt_q.samp[i];
		end
		if (all_hi) begin
			nxt_q.filt = 1'b1;
		end else if (all_lo) begin
			nxt_q.filt = 1'b0;
		end
		nxt_q.edge_prev = edge_src;

		// Counting sequence.
		if (wr_cnt_lo) begin
			nxt_q.count = {q_ff.hold, BUS.wdata};
		end else if (tick) begin
			if (dual_slope(CTRL.waveform_mode_field)) begin
				if (!q_ff.down) begin
					if (q_ff.count >= top) begin
						nxt_q.down  = 1'b1;
						nxt_q.count = q_ff.count - 16'h0001;
					end else begin
						nxt_q.count = q_ff.count + 16'h0001;
					end
				end else if (q_ff.count == `TMR_RST_WORD) begin
					nxt_q.down  = 1'b0;
					nxt_q.count = q_ff.count + 16'h0001;
					ovf_set     = 1'b1;
				end else begin
					nxt_q.count = q_ff.count - 16'h0001;
				end
			end else if (single_wrap(CTRL.waveform_mode_field)) begin
				nxt_q.down = 1'b0;
				if (q_ff.count >= top) begin
					nxt_q.count = `TMR_RST_WORD;
					ovf_set     = 1'b1;
				end else begin
					nxt_q.count = q_ff.count + 16'h0001;
				end
			end else begin
				nxt_q.down = 1'b0;
				if (q_ff.count == `TMR_MAX) begin
					ovf_set = 1'b1;
				end
				if (q_ff.count == top) begin
					nxt_q.count = `TMR_RST_WORD;
				end else begin
					nxt_q.count = q_ff.count + 16'h0001;
				end
			end
		end

		// Byte access through the one shared holding register.
		if (BUS.rd) begin
			unique case (BUS.addr)
				`TMR_LOC_COUNT_LO: begin
					nxt_q.rdata = q_ff.count[7:0];
					nxt_q.hold  = q_ff.count[15:8];
				end
				`TMR_LOC_CAPT_LO: begin
					nxt_q.rdata = q_ff.capt[7:0];
					nxt_q.hold  = q_ff.capt[15:8];
				end
				default: nxt_q.rdata = q_ff.hold;
			endcase
		end
		if (BUS.wr) begin
			if (BUS.addr == `TMR_LOC_COUNT_HI || BUS.addr == `TMR_LOC_CAPT_HI) begin
				nxt_q.hold = BUS.wdata;
			end
			if (BUS.addr == `TMR_LOC_CAPT_LO && capt_top(CTRL.waveform_mode_field)) begin
				nxt_q.capt = {q_ff.hold, BUS.wdata};
			end
		end

		// A capture always overwrites, read or not.
		if (cap_evt) begin
			nxt_q.capt = q_ff.count;
		end

		// Hardware set wins over a clear in the same cycle.
		if (cap_evt) begin
			nxt_q.cap_flag = 1'b1;
		end else if (BUS.clr_cap) begin
			nxt_q.cap_flag = 1'b0;
		end
		if (ovf_set) begin
			nxt_q.ovf_flag = 1'b1;
		end else if (BUS.clr_ovf) begin
			nxt_q.ovf_flag = 1'b0;
		end
		nxt_q.cap_irq = nxt_q.cap_flag && CTRL.capture_irq_enable;
		nxt_q.ovf_irq = nxt_q.ovf_flag && CTRL.overflow_irq_enable;
	end

	always_ff @(posedge CORE_CLK) begin
		if (!RSTN) begin
			q_ff <= '0;
		end else if (CE) begin
			q_ff <= nxt_q;
		end
	end

	assign BUS_RDATA     = q_ff.rdata;
	assign COUNT_VALUE   = q_ff.count;
	assign CAPTURE_VALUE = q_ff.capt;
	assign OVERFLOW_FLAG = q_ff.ovf_flag;
	assign CAPTURE_FLAG  = q_ff.cap_flag;
	assign OVERFLOW_IRQ  = q_ff.ovf_irq;
	assign CAPTURE_IRQ   = q_ff.cap_irq;

	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RSTN);

	property p_stop;
		CE && CTRL.clock_source_select == `TMR_CS_NONE && !wr_cnt_lo
			|=> $stable(COUNT_VALUE);
	endproperty
	a_stop: assert property (p_stop) else $error("counter moved with no clock");

	property p_write_wins;
		logic [15:0] v;
		(CE && wr_cnt_lo && tick, v = {q_ff.hold, BUS.wdata}) |=> COUNT_VALUE == v;
	endproperty
	a_write_wins: assert property (p_write_wins) else $error("write lost to count");

	property p_count_up;
		CE && tick && !wr_cnt_lo && CTRL.waveform_mode_field == 4'h0
			&& COUNT_VALUE != `TMR_MAX |=> COUNT_VALUE == $past(COUNT_VALUE) + 16'h0001;
	endproperty
	a_count_up: assert property (p_count_up) else $error("normal count wrong");

	property p_low_read;
		CE && BUS.rd && BUS.addr == `TMR_LOC_COUNT_LO
			|=> q_ff.hold == $past(COUNT_VALUE[15:8]) && BUS_RDATA == $past(COUNT_VALUE[7:0]);
	endproperty
	a_low_read: assert property (p_low_read) else $error("low read missed holding");

	property p_high_read;
		CE && BUS.rd && BUS.addr == `TMR_LOC_CAPT_HI |=> BUS_RDATA == $past(q_ff.hold);
	endproperty
	a_high_read: assert property (p_high_read) else $error("upper read not holding");

	property p_capture;
		CE && cap_evt |=> CAPTURE_VALUE == $past(COUNT_VALUE) && CAPTURE_FLAG;
	endproperty
	a_capture: assert property (p_capture) else $error("capture not taken");

	property p_set_wins;
		CE && cap_evt && BUS.clr_cap
			|=> CAPTURE_FLAG && CAPTURE_IRQ == $past(CTRL.capture_irq_enable);
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("capture flag lost");

	property p_no_write;
		CE && BUS.wr && BUS.addr == `TMR_LOC_CAPT_LO && !capt_top(CTRL.waveform_mode_field)
			&& !cap_evt |=> $stable(CAPTURE_VALUE);
	endproperty
	a_no_write: assert property (p_no_write) else $error("capture written in wrong mode");

	property p_gate;
		CE && capt_top(CTRL.waveform_mode_field) && !CAPTURE_FLAG |=> !CAPTURE_FLAG;
	endproperty
	a_gate: assert property (p_gate) else $error("capture in top mode");

	property p_filter;
		CE && CTRL.noise_filter_enable && $changed(q_ff.filt)
			|-> q_ff.samp[NC_SAMPLES-1:0] == {NC_SAMPLES{q_ff.filt}};
	endproperty
	a_filter: assert property (p_filter) else $error("filter changed early");

	property p_ovf_max;
		CE && tick && !wr_cnt_lo && CTRL.waveform_mode_field == 4'h0
			&& COUNT_VALUE == `TMR_MAX |=> OVERFLOW_FLAG && COUNT_VALUE == `TMR_RST_WORD;
	endproperty
	a_ovf_max: assert property (p_ovf_max) else $error("overflow missed");

	property p_cap_hold;
		CE && BUS.rd && !BUS.wr && BUS.addr == `TMR_LOC_CAPT_LO
			|=> q_ff.hold == $past(CAPTURE_VALUE[15:8]);
	endproperty
	a_cap_hold: assert property (p_cap_hold) else $error("capture hold missed");

	property p_hold_write;
		CE && BUS.wr && !BUS.rd && BUS.addr[0] |=> q_ff.hold == $past(BUS.wdata);
	endproperty
	a_hold_write: assert property (p_hold_write) else $error("upper write missed holding");

	property p_wrap;
		CE && tick && !wr_cnt_lo && single_wrap(CTRL.waveform_mode_field)
			&& COUNT_VALUE >= top |=> OVERFLOW_FLAG && COUNT_VALUE == `TMR_RST_WORD;
	endproperty
	a_wrap: assert property (p_wrap) else $error("fixed top wrap missed");

	property p_irq;
		CE |=> CAPTURE_IRQ == (CAPTURE_FLAG && $past(CTRL.capture_irq_enable));
	endproperty
	a_irq: assert property (p_irq) else $error("capture request wrong");

	property p_clear;
		CE && BUS.clr_cap && !cap_evt |=> !CAPTURE_FLAG;
	endproperty
	a_clear: assert property (p_clear) else $error("capture flag not cleared");

	c_capture: cover property (CE && cap_evt);
	c_overflow: cover property (CE && !OVERFLOW_FLAG ##1 OVERFLOW_FLAG);
	c_collide: cover property (CE && wr_cnt_lo && tick);
	c_filter: cover property (CE && CTRL.noise_filter_enable && $changed(q_ff.filt));
endmodule
`default_nettype wire

// ===== logic/tmr_regs.svh
// Byte locations, clock select codes, fixed tops and filter depth of the timer.
`ifndef TMR_REGS_SVH
`define TMR_REGS_SVH
`define TMR_LOC_COUNT_LO  2'h0
`define TMR_LOC_COUNT_HI  2'h1
`define TMR_LOC_CAPT_LO   2'h2
`define TMR_LOC_CAPT_HI   2'h3
`define TMR_RST_BYTE      8'h00
`define TMR_RST_WORD      16'h0000
`define TMR_MAX           16'hFFFF
`define TMR_TOP_8BIT      16'h00FF
`define TMR_TOP_9BIT      16'h01FF
`define TMR_TOP_10BIT     16'h03FF
`define TMR_CS_NONE       3'h0
`define TMR_CS_DIRECT     3'h1
`define TMR_CS_PRESCALED  3'h2
`define TMR_CS_EXT_FALL   3'h6
`define TMR_CS_EXT_RISE   3'h7
`define TMR_NC_SAMPLES    4
`endif

// ===== logic/tmr_pkg.sv
// Types shared by the timer counter and its capture unit.
`include "tmr_regs.svh"
package tmr_pkg;
	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [1:0]  addr;
		logic [7:0]  wdata;
		logic        clr_ovf;
		logic        clr_cap;
	} tmr_bus_s;

	typedef struct packed {
		logic [2:0]  clock_source_select;
		logic [3:0]  waveform_mode_field;
		logic        noise_filter_enable;
		logic        edge_rising;
		logic        comparator_capture_select;
		logic        capture_irq_enable;
		logic        overflow_irq_enable;
		logic [15:0] compare_a_top;
	} tmr_ctrl_s;

	typedef struct packed {
		logic [15:0]                  count;
		logic [15:0]                  capt;
		logic [7:0]                   hold;
		logic [7:0]                   rdata;
		logic                         down;
		logic                         ovf_flag;
		logic                         cap_flag;
		logic                         ovf_irq;
		logic                         cap_irq;
		logic                         src_s1;
		logic                         src_s2;
		logic [`TMR_NC_SAMPLES-1:0]   samp;
		logic                         filt;
		logic                         edge_prev;
		logic                         ext_s1;
		logic                         ext_s2;
		logic                         ext_prev;
	} tmr_state_s;
endpackage

// ===== tb/tmr_cpu_model.sv
// Processor-side byte bus model that drives the timer's access strobes.
`timescale 1ns/100ps
`default_nettype none
module tmr_cpu_model (
	input  wire logic        CORE_CLK,
	input  wire logic [7:0]  BUS_RDATA,
	output var  tmr_pkg::tmr_bus_s BUS
);
	import tmr_pkg::*;
	initial BUS = '0;
	// One byte access; released lines show inverted data so stale values never match.
	task automatic acc(input logic w, input logic [1:0] a, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge CORE_CLK);
		#1;
		BUS = '{rd:!w, wr:w, addr:a, wdata:d, clr_ovf:1'b0, clr_cap:1'b0};
		@(posedge CORE_CLK);
		#1;
		BUS = '{rd:1'b0, wr:1'b0, addr:~a, wdata:~d, clr_ovf:1'b0, clr_cap:1'b0};
		q = BUS_RDATA;
	endtask
	// No interrupt exists in this model, so each pair below is never split.
	task automatic wr16(input logic [1:0] lo, input logic [15:0] v);
		logic [7:0] q;
		acc(1'b1, lo + 2'h1, v[15:8], q);
		acc(1'b1, lo, v[7:0], q);
	endtask
	task automatic rd16(input logic [1:0] lo, output logic [15:0] v);
		acc(1'b0, lo, 8'h00, v[7:0]);
		acc(1'b0, lo + 2'h1, 8'h00, v[15:8]);
	endtask
	task automatic clr(input logic ov, input logic cp);
		@(posedge CORE_CLK);
		#1;
		BUS.clr_ovf = ov;
		BUS.clr_cap = cp;
		@(posedge CORE_CLK);
		#1;
		BUS.clr_ovf = 1'b0;
		BUS.clr_cap = 1'b0;
	endtask
endmodule
`default_nettype wire

// ===== tb/testbench.sv
// Self-checking bench for the timer counter and its capture unit.
`timescale 1ns/100ps
`default_nettype none
`include "tmr_regs.svh"
module testbench;
	import tmr_pkg::*;
	logic        CORE_CLK = 1'b0;
	logic        RSTN = 1'b0;
	logic        cap_pin = 1'b0;
	logic        cmp_out = 1'b0;
	logic        ce = 1'b1;
	logic        ext_pin = 1'b0;
	logic        pre_tick = 1'b0;
	tmr_ctrl_s   ctrl = '0;
	tmr_bus_s    bus;
	logic [7:0]  rdata, q;
	logic [15:0] count_v, capt_v, v;
	logic        ovf_f, cap_f, ovf_i, cap_i;
	int          fail_count = 0;
	int          num_checks = 0;
	int          n0, n1;
	always #50 CORE_CLK = ~CORE_CLK;
	tmr_counter_capture uut (.CORE_CLK(CORE_CLK), .RSTN(RSTN), .CE(ce), .BUS(bus),
		.CTRL(ctrl), .PRESCALE_TICK(pre_tick), .EXTERNAL_COUNT_PIN(ext_pin),
		.CAPTURE_INPUT_PIN(cap_pin), .COMPARATOR_OUTPUT(cmp_out), .BUS_RDATA(rdata),
		.COUNT_VALUE(count_v), .CAPTURE_VALUE(capt_v), .OVERFLOW_FLAG(ovf_f),
		.CAPTURE_FLAG(cap_f), .OVERFLOW_IRQ(ovf_i), .CAPTURE_IRQ(cap_i));
	tmr_cpu_model cpu (.CORE_CLK(CORE_CLK), .BUS_RDATA(rdata), .BUS(bus));
	task automatic tk(input int n);
		repeat (n) @(posedge CORE_CLK);
		#1;
	endtask
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		num_checks++;
		if (g !== e) begin
			fail_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic close_out();
		if (fail_count == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// Counts cycles from the input change to the capture flag, with a bound.
	task automatic wait_cap(output int n);
		n = 0;
		while (cap_f !== 1'b1 && n < 40) begin
			tk(1);
			n++;
		end
		if (n == 40) begin
			chk(16'h0, 16'h1);
			close_out();
		end
	endtask
	initial begin
		tk(6);
		RSTN = 1'b1;
		tk(1);
		cpu.wr16(`TMR_LOC_COUNT_LO, 16'h1234);
		tk(3);
		chk(count_v, 16'h1234);
		cpu.rd16(`TMR_LOC_COUNT_LO, v);
		chk(v, 16'h1234);
		cpu.acc(1'b1, `TMR_LOC_COUNT_HI, 8'hA5, q);
		cpu.acc(1'b0, `TMR_LOC_COUNT_HI, 8'h00, q);
		chk({8'h00, q}, 16'h00A5);
		chk(count_v, 16'h1234);
		ctrl.clock_source_select = `TMR_CS_DIRECT;
		ctrl.overflow_irq_enable = 1'b1;
		tk(7);
		cpu.wr16(`TMR_LOC_COUNT_LO, 16'h0100);
		chk(count_v, 16'h0100);
		tk(5);
		chk(count_v, 16'h0105);
		cpu.wr16(`TMR_LOC_COUNT_LO, `TMR_MAX);
		tk(3);
		chk({14'h0, ovf_f, ovf_i}, 16'h0003);
		cpu.clr(1'b1, 1'b0);
		chk({15'h0, ovf_f}, 16'h0000);
		ctrl.clock_source_select = `TMR_CS_NONE;
		cpu.wr16(`TMR_LOC_COUNT_LO, 16'h0ABC);
		ctrl.capture_irq_enable = 1'b1;
		ctrl.edge_rising = 1'b1;
		cap_pin = 1'b1;
		wait_cap(n0);
		chk(capt_v, 16'h0ABC);
		chk({15'h0, cap_i}, 16'h0001);
		cpu.rd16(`TMR_LOC_CAPT_LO, v);
		chk(v, 16'h0ABC);
		cpu.clr(1'b0, 1'b1);
		chk({15'h0, cap_f, cap_i}, 16'h0000);
		cpu.wr16(`TMR_LOC_COUNT_LO, 16'h0DEF);
		ctrl.edge_rising = 1'b0;
		ctrl.noise_filter_enable = 1'b1;
		tk(10);
		cap_pin = 1'b0;
		tk(2);
		cap_pin = 1'b1;
		tk(20);
		chk({15'h0, cap_f}, 16'h0000);
		cap_pin = 1'b0;
		wait_cap(n1);
		chk(capt_v, 16'h0DEF);
		chk(16'(n1 - n0), 16'h0004);
		ctrl.noise_filter_enable = 1'b0;
		ctrl.edge_rising = 1'b1;
		ctrl.comparator_capture_select = 1'b1;
		tk(10);
		cpu.clr(1'b0, 1'b1);
		cpu.wr16(`TMR_LOC_COUNT_LO, 16'h0321);
		cmp_out = 1'b1;
		tk(1);
		cpu.clr(1'b0, 1'b1);
		wait_cap(n0);
		chk({15'h0, cap_f}, 16'h0001);
		chk(capt_v, 16'h0321);
		cpu.clr(1'b0, 1'b1);
		cpu.wr16(`TMR_LOC_CAPT_LO, 16'h4444);
		tk(1);
		chk(capt_v, 16'h0321);
		ctrl.waveform_mode_field = 4'hC;
		cpu.wr16(`TMR_LOC_CAPT_LO, 16'h2468);
		tk(1);
		chk(capt_v, 16'h2468);
		cmp_out = 1'b0;
		tk(10);
		cmp_out = 1'b1;
		tk(20);
		chk({capt_v[14:0], cap_f}, 16'h48D0);
		cpu.acc(1'b1, `TMR_LOC_CAPT_HI, 8'h5A, q);
		cpu.acc(1'b1, `TMR_LOC_COUNT_LO, 8'h77, q);
		tk(1);
		chk(count_v, 16'h5A77);
		ctrl.clock_source_select = `TMR_CS_NONE;
		ctrl.waveform_mode_field = 4'h1;
		cpu.wr16(`TMR_LOC_COUNT_LO, 16'h00FE);
		ctrl.clock_source_select = `TMR_CS_DIRECT;
		tk(3);
		chk(count_v, 16'h00FD);
		ctrl.clock_source_select = `TMR_CS_NONE;
		ctrl.waveform_mode_field = 4'h5;
		cpu.wr16(`TMR_LOC_COUNT_LO, 16'h00FE);
		ctrl.clock_source_select = `TMR_CS_DIRECT;
		tk(2);
		chk(count_v, 16'h0000);
		chk({15'h0, ovf_f}, 16'h0001);
		ce = 1'b0;
		tk(5);
		chk(count_v, 16'h0000);
		ce = 1'b1;
		ctrl.clock_source_select = `TMR_CS_EXT_RISE;
		repeat (3) begin
			ext_pin = 1'b1;
			tk(2);
			ext_pin = 1'b0;
			tk(2);
		end
		tk(3);
		chk(count_v, 16'h0003);
		ctrl.clock_source_select = `TMR_CS_PRESCALED;
		pre_tick = 1'b1;
		tk(1);
		pre_tick = 1'b0;
		tk(2);
		chk(count_v, 16'h0004);
		close_out();
	end
endmodule
`default_nettype wire
